// ===== design/scps_pkg.sv
// Purpose: shared constants of the serial configuration port slave
// Assumes: 20 MHz core clock, serial clock sampled as an ordinary input
// Notes: instruction is 16 bits, register address space is 15 bits
package scps_pkg;
  localparam int unsigned SCPS_INSTR_BITS = 16;
  localparam int unsigned SCPS_ADDR_BITS = 15;
  localparam int unsigned SCPS_DATA_BITS = 8;
  localparam int unsigned SCPS_CNT_BITS = 5;
  localparam logic [4:0] SCPS_INSTR_LAST = 5'h0f;
  localparam logic [2:0] SCPS_BYTE_LAST = 3'h7;
  localparam logic [2:0] SCPS_NIBBLE_LAST = 3'h3;
  localparam logic [14:0] SCPS_CFG_ADDR = 15'h0000;
  // field positions of the interface configuration register
  localparam int unsigned SCPS_SRST_HI = 7;
  localparam int unsigned SCPS_LSB_HI = 6;
  localparam int unsigned SCPS_STEP_HI = 5;
  localparam int unsigned SCPS_SDO_HI = 4;
  localparam int unsigned SCPS_SDO_LO = 3;
  localparam int unsigned SCPS_STEP_LO = 2;
  localparam int unsigned SCPS_LSB_LO = 1;
  localparam int unsigned SCPS_SRST_LO = 0;
  localparam logic [7:0] SCPS_CFG_RESET = 8'h00;
  localparam logic [7:0] SCPS_CFG_WMASK = 8'h7e;
  localparam logic [7:0] SCPS_NIB_MASK = 8'h0f;
  localparam int unsigned SCPS_MEM_DEPTH = 64;
  localparam int unsigned SCPS_SCK_MAX_MHZ = 100;
  typedef enum logic [2:0]
  {
    SCPS_ST_INSTR = 3'b001,
    SCPS_ST_DATA = 3'b010,
    SCPS_ST_IDLE = 3'b100
  } scps_state_t;
endpackage

// ===== design/scps_regmem.sv
// Purpose: small register store behind the serial configuration port
// Assumes: one write port and one read port on core_clk
// Notes: read data comes out of a register, one cycle after the address
`timescale 1ns/1ps
`default_nettype none
module scps_regmem #(
  parameter int unsigned DEPTH = 64,
  parameter int unsigned AW = 6
)
(
  input wire logic core_clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [DEPTH];

  // words beyond the address reach could never be written or read
  if (DEPTH > (1 << AW))
  begin : g_bad_depth
    $error("depth exceeds address width");
  end

  // write and registered read; no reset, memory content is undefined at start
  always_ff @(posedge core_clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

// ===== design/scps_slave.sv
// Purpose: serial configuration port slave, 3- or 4-wire, msb or lsb first
// Assumes: sck and cs_n come from the master, sampled on core_clk
// Notes: serial clock must stay well below core_clk/4 for clean edge detection
`timescale 1ns/1ps
`default_nettype none
module scps_slave #(
  parameter int unsigned MEM_DEPTH = scps_pkg::SCPS_MEM_DEPTH,
  parameter int unsigned MEM_AW = 6
)
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe,
  output logic sdo,
  output logic sdo_oe,
  output logic [7:0] cfg_reg,
  output logic soft_reset_pulse
);
  import scps_pkg::*;

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  // the store is indexed by the low address bits, so it cannot be wider than
  // the serial address; a depth past the address reach would leave holes
  if (MEM_AW > SCPS_ADDR_BITS || MEM_DEPTH < 1)
  begin : g_bad_shape
    $error("memory shape not supported");
  end
  if (MEM_DEPTH > (1 << MEM_AW))
  begin : g_bad_depth
    $error("memory depth exceeds its address width");
  end

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] sck_sync_ff;
  logic [1:0] cs_sync_ff;
  logic [1:0] sdi_sync_ff;
  logic sck_d_ff;

  // two stages per pin; only stage 1 is ever read
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sck_sync_ff <= 2'h0;
      cs_sync_ff <= 2'h3;
      sdi_sync_ff <= 2'h0;
      sck_d_ff <= 1'b0;
    end
    else
    begin
      sck_sync_ff <= {sck_sync_ff[0], sck};
      cs_sync_ff <= {cs_sync_ff[0], cs_n};
      sdi_sync_ff <= {sdi_sync_ff[0], sdio_in};
      sck_d_ff <= sck_sync_ff[1];
    end
  end

  wire sck_s = sck_sync_ff[1];
  wire cs_s = cs_sync_ff[1];
  wire sdi_s = sdi_sync_ff[1];
  // edges count only while chip select is low, so a clock parked by a master is harmless
  wire sck_rise = sck_s & ~sck_d_ff & ~cs_s;
  wire sck_fall = ~sck_s & sck_d_ff & ~cs_s;

  // ----------------------------------------------------------------
  // configuration decode
  // ----------------------------------------------------------------
  logic [7:0] cfg_ff;
  wire lsb_first = cfg_ff[SCPS_LSB_HI] | cfg_ff[SCPS_LSB_LO];
  wire step_up = cfg_ff[SCPS_STEP_HI] | cfg_ff[SCPS_STEP_LO];
  wire four_wire = cfg_ff[SCPS_SDO_HI] | cfg_ff[SCPS_SDO_LO];

  // mirror a nibble so each bit pair stays in step whichever half was written
  function automatic logic [7:0] mirror_cfg(input logic [7:0] v);
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      m[i] = v[i] | v[7 - i];
    end
    return m;
  endfunction

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  scps_state_t state_ff;
  scps_state_t nxt_state;
  logic [4:0] cnt_ff;
  logic [15:0] instr_ff;
  logic [7:0] shift_ff;
  logic [14:0] addr_ff;
  logic rd_ff;
  logic [7:0] tx_ff;
  logic load_ff;

  wire instr_done = (state_ff == SCPS_ST_INSTR) && (cnt_ff == SCPS_INSTR_LAST) && sck_rise;
  wire byte_done = (state_ff == SCPS_ST_DATA) && (cnt_ff[2:0] == SCPS_BYTE_LAST) && sck_rise;
  // in msb-first order the newest bit enters at bit 0, else at the top
  wire [15:0] instr_nxt = lsb_first ? {sdi_s, instr_ff[15:1]} : {instr_ff[14:0], sdi_s};
  wire [7:0] shift_nxt = lsb_first ? {sdi_s, shift_ff[7:1]} : {shift_ff[6:0], sdi_s};
  // lsb first puts the flag last, so it lands at bit 15 as well
  wire instr_rd = instr_nxt[15];
  wire [14:0] instr_addr = instr_nxt[14:0];
  wire [14:0] addr_step = step_up ? addr_ff + 15'h0001 : addr_ff - 15'h0001;

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      SCPS_ST_IDLE:
      begin
        if (!cs_s)
        begin
          nxt_state = SCPS_ST_INSTR;
        end
      end
      SCPS_ST_INSTR:
      begin
        if (cs_s)
        begin
          nxt_state = SCPS_ST_IDLE;
        end
        else if (instr_done)
        begin
          nxt_state = SCPS_ST_DATA;
        end
      end
      SCPS_ST_DATA:
      begin
        if (cs_s)
        begin
          nxt_state = SCPS_ST_IDLE;
        end
      end
    endcase
  end

  // counters and shifters; a rise of cs_n drops any partial byte
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_ff <= SCPS_ST_IDLE;
      cnt_ff <= 5'h00;
      instr_ff <= 16'h0000;
      shift_ff <= 8'h00;
      addr_ff <= 15'h0000;
      rd_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      if (cs_s)
      begin
        cnt_ff <= 5'h00;
      end
      else if (sck_rise)
      begin
        cnt_ff <= instr_done ? 5'h00 : cnt_ff + 5'h01;
        if (state_ff == SCPS_ST_INSTR)
        begin
          instr_ff <= instr_nxt;
        end
        else
        begin
          shift_ff <= shift_nxt;
        end
        if (instr_done)
        begin
          addr_ff <= instr_addr;
          rd_ff <= instr_rd;
        end
        else if (byte_done)
        begin
          addr_ff <= addr_step;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  wire cfg_hit = (addr_ff == SCPS_CFG_ADDR);
  wire wr_byte = byte_done && !rd_ff;
  // first nibble on the wire, whatever the bit order, carries the soft reset bit
  wire [7:0] first_nib = lsb_first ? (shift_nxt & SCPS_NIB_MASK) : (shift_nxt & ~SCPS_NIB_MASK);
  wire [7:0] cfg_new = mirror_cfg(first_nib) & SCPS_CFG_WMASK;
  wire soft_rst = wr_byte && cfg_hit && (first_nib[SCPS_SRST_HI] | first_nib[SCPS_SRST_LO]);
  wire mem_wr = wr_byte && !cfg_hit;

  // config takes effect at the byte's last bit; soft reset clears it
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_ff <= SCPS_CFG_RESET;
      soft_reset_pulse <= 1'b0;
    end
    else
    begin
      soft_reset_pulse <= soft_rst;
      if (soft_rst)
      begin
        cfg_ff <= SCPS_CFG_RESET;
      end
      else if (wr_byte && cfg_hit)
      begin
        cfg_ff <= cfg_new;
      end
    end
  end

  assign cfg_reg = cfg_ff;

  // ----------------------------------------------------------------
  // register store and read path
  // ----------------------------------------------------------------
  logic [7:0] mem_rdata;
  // next read address is known one rise ahead of the byte's first fall
  wire [14:0] rd_addr_sel = instr_done ? instr_addr : (byte_done ? addr_step : addr_ff);

  scps_regmem #(
    .DEPTH(MEM_DEPTH),
    .AW(MEM_AW)
  ) u_regmem (
    .core_clk(core_clk),
    .wr_en(mem_wr),
    .wr_addr(addr_ff[MEM_AW-1:0]),
    .wr_data(shift_nxt),
    .rd_addr(rd_addr_sel[MEM_AW-1:0]),
    .rd_data(mem_rdata)
  );

  wire [7:0] rd_src = cfg_hit ? cfg_ff : mem_rdata;
  wire tx_bit = lsb_first ? tx_ff[0] : tx_ff[7];

  // load the byte one cycle after a boundary, shift on each falling edge
  // the store answers one cycle after its address, hence the wait before loading
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      load_ff <= 1'b0;
      tx_ff <= 8'h00;
      sdio_out <= 1'b0;
      sdo <= 1'b0;
    end
    else
    begin
      load_ff <= ((instr_done || byte_done) && rd_ff) || (instr_done && instr_rd);
      if (load_ff)
      begin
        tx_ff <= rd_src;
      end
      else if (sck_fall && state_ff == SCPS_ST_DATA && rd_ff)
      begin
        sdio_out <= tx_bit;
        sdo <= tx_bit;
        tx_ff <= lsb_first ? {1'b0, tx_ff[7:1]} : {tx_ff[6:0], 1'b0};
      end
    end
  end

  // drive only during a read data phase with chip select low
  wire rd_phase = (state_ff == SCPS_ST_DATA) && rd_ff && !cs_s;
  assign sdio_oe = rd_phase && !four_wire;
  assign sdo_oe = rd_phase && four_wire;
endmodule
`default_nettype wire

// ===== verif/scps_master_model.sv
// Purpose: serial master facing the config port
// Assumes: sck idles low, 400 ns period
// Notes: released sdio shows the inverse of the last bit
`timescale 1ns/1ps
`default_nettype none
module scps_master_model
(
  output logic sck,
  output logic cs_n,
  output logic mosi,
  output logic mosi_oe,
  input wire logic sdio_w,
  input wire logic sdo
);
  // idle: deselected, clock parked
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    mosi_oe = 1'b0;
  end
  // one frame: 16 instruction bits then nbits data bits
  task automatic xfer(input logic rd, input logic [14:0] a, input logic [15:0] wd,
    input int nbits, input logic lsb, input logic w4, output logic [15:0] q);
    logic [15:0] ins;
    int j;
    ins = {rd, a};
    q = 16'h0000;
    cs_n = 1'b0;
    mosi_oe = 1'b1;
    for (int k = 0; k < 16 + nbits; k++)
    begin
      j = (k < 16) ? (lsb ? k : 15 - k) : 8 - 8 * ((k - 16) / 8) + (lsb ? k % 8 : 7 - k % 8);
      if (k == 16 && rd && !w4) mosi_oe = 1'b0;
      mosi = (k < 16) ? ins[j] : (mosi_oe ? wd[j] : ~mosi);
      #200 sck = 1'b1;
      if (k >= 16) q[j] = w4 ? sdo : sdio_w;
      #200 sck = 1'b0;
    end
    #200 cs_n = 1'b1;
    mosi_oe = 1'b0;
    #400;
  endtask
endmodule
`default_nettype wire

// ===== verif/scps_slave_sva.sv
// Purpose: port checker for scps_slave
// Assumes: one core_clk domain, ports only
// Notes: serial edges are slow, so windows stay loose
`timescale 1ns/1ps
`default_nettype none
module scps_slave_sva
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic sdio_in,
  input wire logic sdio_out,
  input wire logic sdio_oe,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic [7:0] cfg_reg,
  input wire logic soft_reset_pulse
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // --------------------------------------------------
  // pin release, routing and config invariants
  // --------------------------------------------------
  // five idle cycles cover the chip select synchroniser
  sequence s_idle; cs_n [*5]; endsequence
  property p_sdio_free; s_idle |-> !sdio_oe; endproperty
  property p_sdo_mode; sdo_oe |-> cfg_reg[4]; endproperty
  property p_sdio_mode; sdio_oe |-> !cfg_reg[4]; endproperty
  property p_lsb_pair; cfg_reg[6] == cfg_reg[1]; endproperty
  property p_step_pair; cfg_reg[5] == cfg_reg[2]; endproperty
  property p_pulse; soft_reset_pulse |=> !soft_reset_pulse; endproperty
  property p_clear; soft_reset_pulse |-> ##[0:2] cfg_reg == 8'h00; endproperty
  property p_hold; s_idle |=> $stable(cfg_reg); endproperty
  a_sdio_free: assert property (p_sdio_free) else $error("sdio driven idle");
  a_sdo_mode: assert property (p_sdo_mode) else $error("sdo in 3-wire");
  a_sdio_mode: assert property (p_sdio_mode) else $error("sdio in 4-wire");
  a_lsb_pair: assert property (p_lsb_pair) else $error("order bits split");
  a_step_pair: assert property (p_step_pair) else $error("step bits split");
  a_pulse: assert property (p_pulse) else $error("long soft reset");
  a_clear: assert property (p_clear) else $error("config not cleared");
  a_hold: assert property (p_hold) else $error("config moved idle");
endmodule
bind scps_slave scps_slave_sva u_sva (.core_clk, .reset_n, .sck, .cs_n, .sdio_in,
  .sdio_out, .sdio_oe, .sdo, .sdo_oe, .cfg_reg, .soft_reset_pulse);
`default_nettype wire

// ===== verif/tb_top.sv
// Purpose: self-checking bench for scps_slave
// Assumes: master model at 400 ns serial period
// Notes: reads capture on the rising serial edge
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import scps_pkg::*;
  logic core_clk, reset_n, sck, cs_n, sdio_out, sdio_oe, sdo, sdo_oe, soft_reset_pulse;
  logic mosi, mosi_oe, sdio_w, sdo_w, srst_seen;
  logic [7:0] cfg_reg;
  logic [15:0] q;
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;
  // shared sdio wire, inverse level once everyone lets go
  assign sdio_w = sdio_oe ? sdio_out : (mosi_oe ? mosi : ~mosi);
  // sdo has no pull either: left undriven it shows the wrong level
  assign sdo_w = sdo_oe ? sdo : ~sdo;
  scps_slave uut (.core_clk, .reset_n, .sck, .cs_n, .sdio_in(sdio_w), .sdio_out,
    .sdio_oe, .sdo, .sdo_oe, .cfg_reg, .soft_reset_pulse);
  scps_master_model m (.sck, .cs_n, .mosi, .mosi_oe, .sdio_w, .sdo(sdo_w));
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // pulse catcher and hang guard
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (soft_reset_pulse) srst_seen <= 1'b1;
    if (cyc == 40000)
    begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("FAIL %0t byte %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("FAIL %0t flag %b exp %b", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic t_msb();
    m.xfer(1'b0, 15'h0005, 16'h3c5a, 16, 1'b0, 1'b0, q);
    m.xfer(1'b1, 15'h0005, 16'h0000, 16, 1'b0, 1'b0, q);
    chk8(q[15:8], 8'h3c);
    chk8(q[7:0], 8'h5a);
    m.xfer(1'b1, 15'h0004, 16'h0000, 8, 1'b0, 1'b0, q);
    chk8(q[15:8], 8'h5a);
  endtask
  task automatic t_cfg();
    m.xfer(1'b0, 15'h0000, 16'h0700, 8, 1'b0, 1'b0, q);
    chk8(cfg_reg, 8'h00);
    chk1(srst_seen, 1'b0);
    m.xfer(1'b0, 15'h0000, 16'h7000, 8, 1'b0, 1'b0, q);
    chk8(cfg_reg, 8'h7e);
    m.xfer(1'b1, 15'h0000, 16'h0000, 8, 1'b1, 1'b1, q);
    chk8(q[15:8], 8'h7e);
  endtask
  // lsb first, 4-wire, step up, then a cut byte
  task automatic t_lsb();
    m.xfer(1'b0, 15'h000a, 16'h1234, 16, 1'b1, 1'b1, q);
    m.xfer(1'b0, 15'h000a, 16'hff00, 4, 1'b1, 1'b1, q);
    m.xfer(1'b1, 15'h000a, 16'h0000, 16, 1'b1, 1'b1, q);
    chk8(q[15:8], 8'h12);
    chk8(q[7:0], 8'h34);
  endtask
  task automatic t_srst();
    m.xfer(1'b0, 15'h0000, 16'h0100, 8, 1'b1, 1'b1, q);
    chk1(srst_seen, 1'b1);
    chk8(cfg_reg, SCPS_CFG_RESET);
    m.xfer(1'b1, 15'h0005, 16'h0000, 8, 1'b0, 1'b0, q);
    chk8(q[15:8], 8'h3c);
  endtask
  initial
  begin
    reset_n = 1'b0;
    srst_seen = 1'b0;
    repeat (12) @(posedge core_clk);
    #5 reset_n = 1'b1;
    repeat (4) @(posedge core_clk);
    // step off the edge so every serial edge of the model lands between core edges
    #5;
    chk8(cfg_reg, SCPS_CFG_RESET);
    chk1(sdio_oe, 1'b0);
    t_msb();
    t_cfg();
    t_lsb();
    t_srst();
    give_verdict();
  end
endmodule
`default_nettype wire
